// ===== bench/apf_codec.sv
/*
  Behavioural codec on the far side of the frame-sync pins.
  Assumes the bench resolves each pin from all drivers, pulled low.
*/
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Codec model
// ----------------------------------------
module apf_codec
#(
  parameter int FRAME = 4
)
(
  // Bench control
  input wire  logic run,
  input wire  logic fs_en,
  input wire  logic fl_en,
  input wire  logic fl_val,
  // Pin side
  output var  logic sck,
  output var  logic fs_o,
  output wire logic fs_oe,
  output wire logic fl_o,
  output wire logic fl_oe
);
  int cnt;
  assign fs_oe = fs_en;
  assign fl_oe = fl_en;
  assign fl_o  = fl_val;
  initial
  begin
    sck = 0;
    fs_o = 0;
  end
  // Bit clock only while run is high, frame sync set in the low half
  always
  begin
    wait (run);
    cnt = 0;
    #1;
    while (run)
    begin
      fs_o = fs_en && (cnt % FRAME == 0);
      #32 sck = 1;
      #32 sck = 0;
      cnt++;
    end
    fs_o = 0;
  end
endmodule
`default_nettype wire

// ===== bench/apf_mon_monitor.sv
/*
  Assertion checker for the frame-sync pin control block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Checker
// ----------------------------------------
module apf_mon
(
  // System
  input wire        sys_clk,
  input wire        rst,
  // Register bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // Pins and strobes
  input wire        rx_framepulse_pin_oe,
  input wire        tx_framepulse_pin_o,
  input wire        tx_framepulse_pin_oe,
  input wire        tx_frame_start,
  input wire        rx_frame_start
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  pins_idle_a: assert property ($past(rst) |-> !rx_framepulse_pin_oe && !tx_framepulse_pin_oe)
    else $error("pin driven after reset");
  tx_pulse_a: assert property (tx_frame_start |=> !tx_frame_start)
    else $error("tx frame strobe too long");
  rx_pulse_a: assert property (rx_frame_start |=> !rx_frame_start)
    else $error("rx frame strobe too long");
  tx_drive_a: assert property (tx_frame_start && tx_framepulse_pin_oe |-> ##[1:2] tx_framepulse_pin_o)
    else $error("tx frame pulse missing on pin");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  ar_gate_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
endmodule
`default_nettype wire

// ===== bench/tb.sv
/*
  Self-checking bench of the frame-sync pin control block.
  Assumes the register map header and the codec model.
*/
`include "apf_map.vh"
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Bench
// ----------------------------------------
module tb;
  localparam [7:0] a_ct = `APF_OFF_COMMON_CTRL, a_rx = `APF_OFF_RX_CLK_CTRL, a_tx = `APF_OFF_TX_CLK_CTRL;
  localparam [7:0] a_fl = `APF_OFF_FLAG_CTRL, a_st = `APF_OFF_COMMON_STAT, a_gp = `APF_OFF_GPIO_CTRL;
  localparam [1:0] ok = `APF_RESP_OKAY, se = `APF_RESP_SLVERR;
  logic sys_clk = 0, rst = 1;
  logic [7:0] awa, ara;
  logic [31:0] wd;
  logic awv, wv, bre, arv, rre, buf_act, run, fs_en, fl_en, fl_val, rck_en, tx_prev;
  wire awr, wrdy, bv, arr, rv, rxo, rxoe, txo, txoe, txf, txs, rxf, rxs, sck, fso, fsoe, flo, floe;
  wire [1:0] br, rr;
  wire [31:0] rdt;
  wire rx_line = rxoe ? rxo : (floe ? flo : 1'b0);
  wire tx_line = txoe ? txo : (fsoe ? fso : 1'b0);
  int n_errors = 0, comparisons = 0, n_txf = 0, n_rxf = 0, n_txp = 0, n_txs = 0, n_rxs = 0;
  always #2 sys_clk = ~sys_clk;
  apf_framepulse_ctrl uut (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .tx_bitclock_pin_i(sck), .rx_bitclock_pin_i(sck & rck_en), .rx_framepulse_pin_i(rx_line),
    .rx_framepulse_pin_o(rxo), .rx_framepulse_pin_oe(rxoe), .tx_framepulse_pin_i(tx_line),
    .tx_framepulse_pin_o(txo), .tx_framepulse_pin_oe(txoe), .tx_buffer_active(buf_act),
    .tx_frame_start(txf), .tx_slot_start(txs), .rx_frame_start(rxf), .rx_slot_start(rxs));
  apf_codec codec (.run(run), .fs_en(fs_en), .fl_en(fl_en), .fl_val(fl_val), .sck(sck), .fs_o(fso),
    .fs_oe(fsoe), .fl_o(flo), .fl_oe(floe));
  // Strobe and pin pulse counters
  always @(posedge sys_clk)
  begin
    n_txf = n_txf + txf;
    n_rxf = n_rxf + rxf;
    n_txs = n_txs + txs;
    n_rxs = n_rxs + rxs;
    n_txp = n_txp + (tx_line && !tx_prev);
    tx_prev = tx_line;
  end
  task conclude;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bre <= 1;
    do
    begin
      @(posedge sys_clk);
      if (awr) awv <= 0;
      if (wrdy) wv <= 0;
    end
    while (bv !== 1'b1);
    bre <= 0;
    chk("bresp", e, br);
    @(posedge sys_clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    ara <= a;
    arv <= 1;
    rre <= 1;
    do
    begin
      @(posedge sys_clk);
      if (arr) arv <= 0;
    end
    while (rv !== 1'b1);
    rre <= 0;
    chk("rdata", e, rdt);
    chk("rresp", er, rr);
    @(posedge sys_clk);
  endtask
  task bits(input int n);
    n_txf = 0;
    n_rxf = 0;
    n_txp = 0;
    n_txs = 0;
    n_rxs = 0;
    run <= 1;
    repeat (n * 16) @(posedge sys_clk);
    run <= 0;
    repeat (40) @(posedge sys_clk);
  endtask
  task pause;
    repeat (4) @(posedge sys_clk);
  endtask
  initial
  begin
    {awv, wv, bre, arv, rre, buf_act, run, fs_en, fl_en, fl_val, rck_en, tx_prev} = 0;
    {awa, ara, wd} = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    chk("pins", 0, {rxoe, txoe, rxo, txo});
    rd(a_ct, 0, ok);
    rd(a_gp, 0, ok);
    rd(8'h20, 0, se);
    wr(a_st, 32'h0000_0001, se);
    wr(a_tx, 32'hFFFF_FFFF, ok);
    rd(a_tx, 32'h00FF_1F01, ok);
    wr(a_gp, 32'h0000_0016, ok);
    pause;
    chk("gpio", 3'b110, {rxoe, rxo, txoe});
    rd(a_st, 32'h0000_0002, ok);
    wr(a_gp, 32'h0000_0029, ok);
    pause;
    chk("gpio", 3'b011, {rxoe, txoe, txo});
    rd(a_st, 32'h0000_0004, ok);
    wr(a_gp, 32'h0000_000F, ok);
    pause;
    chk("gpio", 0, {rxoe, txoe});
    wr(a_tx, 32'h0003_0001, ok);
    wr(a_rx, 32'h0003_0001, ok);
    wr(a_ct, 32'h0000_0001, ok);
    pause;
    chk("dir", 2'b11, {rxoe, txoe});
    bits(12);
    chk("txf", 3, n_txf);
    chk("rxf", 0, n_rxf);
    chk("txp", 3, n_txp);
    rck_en <= 1;
    bits(12);
    chk("rxf", 3, n_rxf);
    rck_en <= 0;
    wr(a_ct, 32'h0000_0003, ok);
    wr(a_fl, 32'h0000_0001, ok);
    bits(12);
    chk("rxf", 3, n_rxf);
    chk("flag", 2'b11, {rxoe, rxo});
    wr(a_fl, 32'h0000_0000, ok);
    bits(4);
    chk("flag", 2'b10, {rxoe, rxo});
    wr(a_rx, 32'h0003_0000, ok);
    fl_en <= 1;
    fl_val <= 1;
    bits(4);
    chk("flag", 0, rxoe);
    rd(a_st, 32'h0000_0003, ok);
    fl_val <= 0;
    bits(4);
    rd(a_st, 32'h0000_0000, ok);
    fl_en <= 0;
    wr(a_rx, 32'h0003_0001, ok);
    wr(a_ct, 32'h0000_0007, ok);
    buf_act <= 1;
    pause;
    chk("bufen", 2'b11, {rxoe, rxo});
    buf_act <= 0;
    pause;
    chk("bufen", 2'b10, {rxoe, rxo});
    wr(a_tx, 32'h0003_0000, ok);
    wr(a_ct, 32'h0000_0001, ok);
    fs_en <= 1;
    bits(12);
    chk("txdir", 0, txoe);
    chk("txf", 3, n_txf);
    fs_en <= 0;
    wr(a_ct, 32'h0000_0000, ok);
    wr(a_tx, 32'h0003_0101, ok);
    wr(a_fl, 32'h0000_0001, ok);
    wr(a_ct, 32'h0000_000B, ok);
    bits(12);
    chk("txs", 6, n_txs);
    chk("rxs", 6, n_rxs);
    chk("txf", 3, n_txf);
    chk("flag", 2'b11, {rxoe, rxo});
    wr(a_fl, 32'h0000_0000, ok);
    bits(1);
    chk("flag", 2'b10, {rxoe, rxo});
    wr(a_fl, 32'h0000_0001, ok);
    bits(1);
    chk("flag", 2'b10, {rxoe, rxo});
    bits(1);
    chk("flag", 2'b11, {rxoe, rxo});
    conclude;
  end
  initial
  begin
    #40000;
    n_errors++;
    conclude;
  end
endmodule
bind apf_framepulse_ctrl apf_mon u_mon (.sys_clk(sys_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .rx_framepulse_pin_oe(rx_framepulse_pin_oe),
  .tx_framepulse_pin_o(tx_framepulse_pin_o), .tx_framepulse_pin_oe(tx_framepulse_pin_oe),
  .tx_frame_start(tx_frame_start), .rx_frame_start(rx_frame_start));
`default_nettype wire

// ===== logic/apf_framepulse_ctrl.v
/*
  Frame-sync pin control of the second serial audio port, with an
  AXI4-Lite register slave.
  Assumes bit clock and frame-sync pins are asynchronous to sys_clk and
  toggle far slower than it; the transmitter drives tx_buffer_active.
*/
// Overview of operation
// RL1: Sharing off: receive pin is receiver frame sync
// RL2: Sharing on, buffer select off: flag one
// RL3: Sharing, buffer select, output: drive buffer enable
// RL4: Flag direction follows receive frame direction bit
// RL5: Output flag updates at frame or slot
// RL6: Input flag sampled at frame or slot
// RL7: Synchronous: transmit pin frames everyone
// RL8: Asynchronous: transmit pin frames transmitters only
// RL9: Transmit frame direction bit sets pin direction
// RL10: GPIO mode: pin input, output or disconnected
// RL11: Reset leaves both pins GPIO disconnected
// RL12: Transmit bit clock clocks receivers when synchronous
// RL13: External frame sync aligned to its bit clock
`include "apf_map.vh"
`timescale 1ns/10ps
`default_nettype none

module apf_framepulse_ctrl
(
  // System
  input  wire        sys_clk,
  input  wire        rst,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Serial pins
  input  wire        tx_bitclock_pin_i,
  input  wire        rx_bitclock_pin_i,
  input  wire        rx_framepulse_pin_i,
  output reg         rx_framepulse_pin_o,
  output reg         rx_framepulse_pin_oe,
  input  wire        tx_framepulse_pin_i,
  output reg         tx_framepulse_pin_o,
  output reg         tx_framepulse_pin_oe,
  // Transmitter and receiver side
  input  wire        tx_buffer_active,
  output reg         tx_frame_start,
  output reg         tx_slot_start,
  output reg         rx_frame_start,
  output reg         rx_slot_start
);

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  reg  [7:0]  aw_addr_q;
  reg         aw_full_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         w_full_q;
  reg  [31:0] common_control_reg;
  reg  [31:0] rx_clock_control_reg;
  reg  [31:0] tx_clock_control_reg;
  reg  [31:0] flag_ctrl_q;
  reg  [31:0] gpio_ctrl_q;
  reg         in_flag_one_bit;
  reg  [31:0] rd_data_d;
  reg         rd_hit_d;
  wire [31:0] wr_mask;
  wire [31:0] common_status_reg;
  wire        wr_fire;
  wire        wr_hit;

  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready  = ~w_full_q;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                    {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wr_hit  = (aw_addr_q == `APF_OFF_COMMON_CTRL) |
                   (aw_addr_q == `APF_OFF_RX_CLK_CTRL) |
                   (aw_addr_q == `APF_OFF_TX_CLK_CTRL) |
                   (aw_addr_q == `APF_OFF_FLAG_CTRL) |
                   (aw_addr_q == `APF_OFF_GPIO_CTRL);

  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [31:0] lanes;
    input [31:0] keep;
    begin
      merge = ((old_v & ~lanes) | (new_v & lanes)) & keep;
    end
  endfunction

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_addr_q            <= 8'h00;
      aw_full_q            <= 1'b0;
      w_data_q             <= 32'h0000_0000;
      w_strb_q             <= 4'h0;
      w_full_q             <= 1'b0;
      s_axi_bvalid         <= 1'b0;
      s_axi_bresp          <= `APF_RESP_OKAY;
      common_control_reg   <= `APF_RST_VALUE; // [RL11]
      rx_clock_control_reg <= `APF_RST_VALUE;
      tx_clock_control_reg <= `APF_RST_VALUE;
      flag_ctrl_q          <= `APF_RST_VALUE;
      gpio_ctrl_q          <= `APF_RST_VALUE; // [RL11]
    end
    else
    begin
      if (s_axi_awvalid & ~aw_full_q)
      begin
        aw_addr_q <= s_axi_awaddr;
        aw_full_q <= 1'b1;
      end
      if (s_axi_wvalid & ~w_full_q)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_full_q <= 1'b1;
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_fire)
      begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `APF_RESP_OKAY : `APF_RESP_SLVERR;
        case (aw_addr_q)
          `APF_OFF_COMMON_CTRL: common_control_reg <= merge(common_control_reg,
                                  w_data_q, wr_mask, `APF_MASK_COMMON_CTRL);
          `APF_OFF_RX_CLK_CTRL: rx_clock_control_reg <= merge(rx_clock_control_reg,
                                  w_data_q, wr_mask, `APF_MASK_CLK_CTRL);
          `APF_OFF_TX_CLK_CTRL: tx_clock_control_reg <= merge(tx_clock_control_reg,
                                  w_data_q, wr_mask, `APF_MASK_CLK_CTRL);
          `APF_OFF_FLAG_CTRL:   flag_ctrl_q <= merge(flag_ctrl_q,
                                  w_data_q, wr_mask, `APF_MASK_FLAG_CTRL);
          `APF_OFF_GPIO_CTRL:   gpio_ctrl_q <= merge(gpio_ctrl_q,
                                  w_data_q, wr_mask, `APF_MASK_GPIO_CTRL);
          default:              ;
        endcase
      end
    end
  end

  always @*
  begin
    rd_hit_d  = 1'b1;
    rd_data_d = 32'h0000_0000;
    case (s_axi_araddr)
      `APF_OFF_COMMON_CTRL: rd_data_d = common_control_reg;
      `APF_OFF_RX_CLK_CTRL: rd_data_d = rx_clock_control_reg;
      `APF_OFF_TX_CLK_CTRL: rd_data_d = tx_clock_control_reg;
      `APF_OFF_FLAG_CTRL:   rd_data_d = flag_ctrl_q;
      `APF_OFF_COMMON_STAT: rd_data_d = common_status_reg;
      `APF_OFF_GPIO_CTRL:   rd_data_d = gpio_ctrl_q;
      default:              rd_hit_d  = 1'b0;
    endcase
  end

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `APF_RESP_OKAY;
    end
    else if (s_axi_arvalid & ~s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data_d;
      s_axi_rresp  <= rd_hit_d ? `APF_RESP_OKAY : `APF_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Pin synchronisers and bit clock edges
  // ---------------------------------------------------------------
  reg  [3:0] pin_s1_q;
  reg  [3:0] pin_s2_q;
  reg  [1:0] clk_s3_q;
  wire [1:0] bit_edge;

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      clk_s3_q <= 2'h0;
    end
    else
    begin
      pin_s1_q <= {rx_bitclock_pin_i, tx_bitclock_pin_i,
                   rx_framepulse_pin_i, tx_framepulse_pin_i};
      pin_s2_q <= pin_s1_q;
      clk_s3_q <= pin_s2_q[3:2];
    end
  end

  assign bit_edge = pin_s2_q[3:2] & ~clk_s3_q;

  // ---------------------------------------------------------------
  // Frame and slot timing, channel 0 transmit, channel 1 receive
  // ---------------------------------------------------------------
  wire       port_en     = common_control_reg[`APF_CTRL_PORT_EN];
  wire       sharing     = common_control_reg[`APF_CTRL_SHARING];
  wire       txbuf_sel   = common_control_reg[`APF_CTRL_TXBUF_SEL];
  wire       network     = common_control_reg[`APF_CTRL_NETWORK];
  wire       rx_framepulse_dir = rx_clock_control_reg[`APF_CLK_DIR];
  wire       tx_framepulse_dir = tx_clock_control_reg[`APF_CLK_DIR];
  wire [1:0] fs_dir      = {rx_framepulse_dir, tx_framepulse_dir};
  wire [1:0] ch_frame;
  wire [1:0] ch_slot;
  wire [1:0] ch_pulse;

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1)
    begin : g_ch
      reg  [7:0] cnt_q;
      reg  [4:0] scnt_q;
      reg        prev_q;
      reg        pulse_q;
      wire [31:0] cfg = (c == 0) ? tx_clock_control_reg : rx_clock_control_reg;
      wire [7:0] len  = cfg[`APF_CLK_LEN_HI:`APF_CLK_LEN_LO];
      wire [4:0] slen = cfg[`APF_CLK_SLOT_HI:`APF_CLK_SLOT_LO];
      wire       ext  = pin_s2_q[c] & ~prev_q; // [RL13]
      wire       fst  = fs_dir[c] ? (cnt_q == 8'h00) : ext;
      wire [7:0] idx  = fst ? 8'h00 : cnt_q;
      wire [4:0] sidx = fst ? 5'h00 : scnt_q;

      assign ch_frame[c] = bit_edge[c] & fst;
      assign ch_slot[c]  = bit_edge[c] & (fst | (network & (sidx == 5'h00)));
      assign ch_pulse[c] = pulse_q;

      always @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          cnt_q   <= 8'h00;
          scnt_q  <= 5'h00;
          prev_q  <= 1'b0;
          pulse_q <= 1'b0;
        end
        else if (~port_en)
        begin
          cnt_q   <= 8'h00;
          scnt_q  <= 5'h00;
          pulse_q <= 1'b0;
        end
        else if (bit_edge[c])
        begin
          prev_q  <= pin_s2_q[c];
          cnt_q   <= (idx == len) ? 8'h00 : idx + 8'h01;
          scnt_q  <= (sidx == slen) ? 5'h00 : sidx + 5'h01;
          pulse_q <= fs_dir[c] & fst;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Serial flag one and strobes
  // ---------------------------------------------------------------
  reg  flag_pin_q;
  wire flag_mode = sharing & ~txbuf_sel;
  wire flag_ev   = ch_slot[0]; // [RL5] [RL6]

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      flag_pin_q      <= 1'b0;
      in_flag_one_bit <= 1'b0;
      tx_frame_start  <= 1'b0;
      tx_slot_start   <= 1'b0;
      rx_frame_start  <= 1'b0;
      rx_slot_start   <= 1'b0;
    end
    else
    begin
      if (port_en & flag_mode & flag_ev)
      begin
        flag_pin_q <= flag_ctrl_q[`APF_FLAG_OUT_ONE]; // [RL5]
        if (~rx_framepulse_dir)
          in_flag_one_bit <= pin_s2_q[1]; // [RL6]
      end
      tx_frame_start <= port_en & ch_frame[0];
      tx_slot_start  <= port_en & ch_slot[0];
      rx_frame_start <= port_en & (sharing ? ch_frame[0] : ch_frame[1]); // [RL7] [RL8] [RL12]
      rx_slot_start  <= port_en & (sharing ? ch_slot[0] : ch_slot[1]); // [RL12]
    end
  end

  assign common_status_reg = {29'h000_0000, pin_s2_q[0], pin_s2_q[1], in_flag_one_bit};

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  wire [1:0] gpio_line_a = gpio_ctrl_q[`APF_GPIO_A_CFG_LO+1:`APF_GPIO_A_CFG_LO];
  wire [1:0] gpio_line_b = gpio_ctrl_q[`APF_GPIO_B_CFG_LO+1:`APF_GPIO_B_CFG_LO];
  reg        rx_o_d;
  reg        rx_oe_d;
  reg        tx_o_d;
  reg        tx_oe_d;

  always @*
  begin
    rx_o_d  = 1'b0;
    rx_oe_d = 1'b0;
    tx_o_d  = 1'b0;
    tx_oe_d = 1'b0;
    if (~port_en)
    begin
      rx_oe_d = (gpio_line_a == `APF_GPIO_OUT); // [RL10]
      rx_o_d  = rx_oe_d & gpio_ctrl_q[`APF_GPIO_A_OUT];
      tx_oe_d = (gpio_line_b == `APF_GPIO_OUT); // [RL10]
      tx_o_d  = tx_oe_d & gpio_ctrl_q[`APF_GPIO_B_OUT];
    end
    else
    begin
      tx_oe_d = tx_framepulse_dir; // [RL9]
      tx_o_d  = ch_pulse[0]; // [RL7] [RL8]
      rx_oe_d = rx_framepulse_dir; // [RL4]
      if (~sharing)
        rx_o_d = ch_pulse[1]; // [RL1]
      else if (~txbuf_sel)
        rx_o_d = flag_pin_q; // [RL2]
      else
        rx_o_d = rx_framepulse_dir & tx_buffer_active; // [RL3]
    end
  end

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_framepulse_pin_o  <= 1'b0;
      rx_framepulse_pin_oe <= 1'b0; // [RL11]
      tx_framepulse_pin_o  <= 1'b0;
      tx_framepulse_pin_oe <= 1'b0; // [RL11]
    end
    else
    begin
      rx_framepulse_pin_o  <= rx_o_d;
      rx_framepulse_pin_oe <= rx_oe_d;
      tx_framepulse_pin_o  <= tx_o_d;
      tx_framepulse_pin_oe <= tx_oe_d;
    end
  end

endmodule

`default_nettype wire

// ===== logic/apf_map.vh
/*
  Register map, field positions and reset values of the audio port
  frame-sync pin control block.
  Assumes byte addressing on a 32-bit AXI4-Lite register bus.
*/
`ifndef APF_MAP_VH
`define APF_MAP_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define APF_ADDR_W           8
`define APF_OFF_COMMON_CTRL  8'h00
`define APF_OFF_RX_CLK_CTRL  8'h04
`define APF_OFF_TX_CLK_CTRL  8'h08
`define APF_OFF_FLAG_CTRL    8'h0C
`define APF_OFF_COMMON_STAT  8'h10
`define APF_OFF_GPIO_CTRL    8'h14

// ---------------------------------------------------------------
// Writable bits and reset values
// ---------------------------------------------------------------
`define APF_MASK_COMMON_CTRL 32'h0000_000F
`define APF_MASK_CLK_CTRL    32'h00FF_1F01
`define APF_MASK_FLAG_CTRL   32'h0000_0001
`define APF_MASK_GPIO_CTRL   32'h0000_003F
`define APF_RST_VALUE        32'h0000_0000

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define APF_CTRL_PORT_EN     0
`define APF_CTRL_SHARING     1
`define APF_CTRL_TXBUF_SEL   2
`define APF_CTRL_NETWORK     3
`define APF_CLK_DIR          0
`define APF_CLK_SLOT_LO      8
`define APF_CLK_SLOT_HI      12
`define APF_CLK_LEN_LO       16
`define APF_CLK_LEN_HI       23
`define APF_FLAG_OUT_ONE     0
`define APF_STAT_IN_ONE      0
`define APF_STAT_RX_PIN      1
`define APF_STAT_TX_PIN      2
`define APF_GPIO_A_CFG_LO    0
`define APF_GPIO_B_CFG_LO    2
`define APF_GPIO_A_OUT       4
`define APF_GPIO_B_OUT       5

// ---------------------------------------------------------------
// Line modes and bus answers
// ---------------------------------------------------------------
`define APF_GPIO_OFF         2'h0
`define APF_GPIO_IN          2'h1
`define APF_GPIO_OUT         2'h2
`define APF_RESP_OKAY        2'h0
`define APF_RESP_SLVERR      2'h2

`endif
